/* File: hw/edge_irq_pkg.sv */
// Purpose: Constants and carrier types for the edge interrupt flag unit
// Assumes: 8-bit special function register bus, one system clock
// Notes:   What this block does is listed below
//
// What this block does
// RULE1: Flag bits 7:5 read zero, ignore writes
// RULE2: Spare flags set only by software writing one
// RULE3: Serializer flag set on holding register empty
// RULE4: Software clears serializer flag before next byte
// RULE5: Edge flags set even when masked, never hardware-cleared
// RULE6: Sources react to transitions only, not levels
// RULE7: Mode bit picks rising or both edges
// RULE8: Polarity bit inverts selected pin before detector
// RULE9: Source b selector maps 101 to pin 9
// RULE10: Source a selector maps 101 to pin 8
// RULE11: Pins sampled by system clock before detection
// RULE12: Drivers hold pulses over two sampling periods
// RULE13: Detected edges drive timer capture events
// RULE14: Writing zero clears flag; request needs enable
// RULE15: Source enable zero blocks, one allows request
package edge_irq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_SELECT_POLARITY_ADDR     = 8'hB7;
    localparam logic [7:0] PENDING_INTERRUPT_FLAGS_ADDR = 8'hBF;
    localparam logic [7:0] PIN_SELECT_POLARITY_RESET    = 8'h00;
    localparam logic [4:0] PENDING_FLAGS_RESET          = 5'h00;
    localparam logic [7:0] FLAGS_WRITABLE_MASK          = 8'h1F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EXT_A_SEL_LSB   = 0;
    localparam int EXT_A_INVERT    = 3;
    localparam int EXT_B_SEL_LSB   = 4;
    localparam int EXT_B_INVERT    = 7;
    localparam int FLAG_EXT_A      = 0;
    localparam int FLAG_EXT_B      = 1;
    localparam int FLAG_SERIALIZER = 2;
    localparam int FLAG_SPARE_A    = 3;
    localparam int FLAG_SPARE_B    = 4;
    localparam int NUM_FLAGS       = 5;
    localparam int NUM_SOURCES     = 2;
    localparam int NUM_PINS        = 10;

    // Pin reached by selector code 101, per source
    localparam logic [3:0] EXT_A_ALT_PIN = 4'h8;
    localparam logic [3:0] EXT_B_ALT_PIN = 4'h9;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } sfr_req_type;

    typedef struct packed {
        logic [4:0] enable;
        logic [1:0] doubleEdge;
    } irq_ctrl_type;

endpackage

/* File: hw/edge_irq_pin_flags.sv */
// Purpose: Pin-selected edge interrupts with sticky pending flags
// Assumes: Register bus on mclk; gpio pins asynchronous
// Notes:   Enables and edge modes come from registers held elsewhere
`timescale 1ns/100ps
module edge_irq_pin_flags (
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    input  wire edge_irq_pkg::sfr_req_type  sfrReq,
    output logic [7:0]                      sfrRdData,
    input  wire edge_irq_pkg::irq_ctrl_type irqCtrl,
    input  wire logic [9:0]                 gpioPin,
    input  wire logic                       txHoldEmpty,
    output logic [4:0]                      irqReq,
    output logic                            timer2Capture,
    output logic                            timer3Capture
);
    import edge_irq_pkg::*;

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic [7:0] pinCfg_ff;
    logic       cfgWr;
    logic       flagWr;

    assign cfgWr  = sfrReq.wrEn && (sfrReq.addr == PIN_SELECT_POLARITY_ADDR);
    assign flagWr = sfrReq.wrEn &&
                    (sfrReq.addr == PENDING_INTERRUPT_FLAGS_ADDR);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pinCfg_ff <= PIN_SELECT_POLARITY_RESET;
        end else if (cfgWr) begin
            pinCfg_ff <= sfrReq.wrData;
        end
    end

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Two stages; pulses under two clocks may be lost
    logic [9:0] pinMeta_ff;
    logic [9:0] pinSync_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pinMeta_ff <= 10'h000;
            pinSync_ff <= 10'h000;
        end else begin
            pinMeta_ff <= gpioPin; // RULE11
            pinSync_ff <= pinMeta_ff; // RULE11
        end
    end

    // ------------------------------------------------------------
    // Per-source select, invert and edge detect
    // ------------------------------------------------------------
    logic [1:0] srcLevel;
    logic [1:0] srcLevel_ff;
    logic [1:0] edgeHit;
    logic [2:0] selCode [NUM_SOURCES];
    logic [3:0] pinIdx  [NUM_SOURCES];

    // Previous-level register cleared at reset, so a pin sitting
    // high at release shows as a rising edge once it is sampled
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            srcLevel_ff <= 2'h0;
        end else begin
            srcLevel_ff <= srcLevel;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SOURCES; s++) begin : g_src
            localparam int SEL_LSB = (s == 0) ? EXT_A_SEL_LSB : EXT_B_SEL_LSB;
            localparam int INV_BIT = (s == 0) ? EXT_A_INVERT : EXT_B_INVERT;
            localparam logic [3:0] ALT = (s == 0) ? EXT_A_ALT_PIN
                                                  : EXT_B_ALT_PIN;
            assign selCode[s] = pinCfg_ff[SEL_LSB +: 3];
            always_comb begin
                if (selCode[s] == 3'h5) begin
                    pinIdx[s] = ALT; // RULE9 RULE10
                end else begin
                    pinIdx[s] = {1'b0, selCode[s]};
                end
            end
            assign srcLevel[s] = pinSync_ff[pinIdx[s]] ^
                                 pinCfg_ff[INV_BIT]; // RULE8
            // Rising edge, or any change in double-edge mode
            assign edgeHit[s] = irqCtrl.doubleEdge[s] ?
                (srcLevel[s] ^ srcLevel_ff[s]) :
                (srcLevel[s] & ~srcLevel_ff[s]); // RULE6 RULE7
        end
    endgenerate

    assign timer2Capture = edgeHit[0]; // RULE13
    assign timer3Capture = edgeHit[1]; // RULE13

    // ------------------------------------------------------------
    // Serializer empty event
    // ------------------------------------------------------------
    logic txEmpty_ff;
    logic txEmptyRise;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            txEmpty_ff <= 1'b0;
        end else begin
            txEmpty_ff <= txHoldEmpty;
        end
    end

    assign txEmptyRise = txHoldEmpty & ~txEmpty_ff;

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    logic [4:0] flags_ff;
    logic [4:0] hwSet;
    logic [4:0] nxt_flags;

    assign hwSet = {2'h0, txEmptyRise, edgeHit}; // RULE2 RULE3 RULE5

    // Hardware set beats a software clear in the same cycle
    always_comb begin
        nxt_flags = flags_ff;
        if (flagWr) begin
            nxt_flags = sfrReq.wrData[4:0]; // RULE14 RULE1
        end
        nxt_flags = nxt_flags | hwSet; // RULE5
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flags_ff <= PENDING_FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign irqReq = flags_ff & irqCtrl.enable; // RULE14 RULE15

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sfrRdData <= 8'h00;
        end else if (sfrReq.rdEn) begin
            case (sfrReq.addr)
                PIN_SELECT_POLARITY_ADDR:     sfrRdData <= pinCfg_ff;
                PENDING_INTERRUPT_FLAGS_ADDR:
                    sfrRdData <= {3'h0, flags_ff}; // RULE1
                default:                      sfrRdData <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Counts edges since reset so that the level, edge-mode and sampler checks looking back in time
    // never compare against values from inside the reset window
    logic [1:0] settle_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            settle_ff <= 2'h0;
        end else if (settle_ff != 2'h3) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    AST_UPPER_ZERO: assert property ( // RULE1
        @(posedge mclk) disable iff (!reset_n)
        $past(sfrReq.rdEn) &&
        ($past(sfrReq.addr) == PENDING_INTERRUPT_FLAGS_ADDR)
        |-> sfrRdData[7:5] == 3'h0)
        else $error("Upper flag bits not zero");

    AST_FLAGS_READBACK: assert property ( // RULE1
        @(posedge mclk) disable iff (!reset_n)
        $past(sfrReq.rdEn) &&
        ($past(sfrReq.addr) == PENDING_INTERRUPT_FLAGS_ADDR)
        |-> sfrRdData[4:0] == $past(flags_ff))
        else $error("Flag read data wrong");

    AST_SPARE_SET: assert property ( // RULE2
        @(posedge mclk) disable iff (!reset_n)
        flagWr && sfrReq.wrData[FLAG_SPARE_A] |=> flags_ff[FLAG_SPARE_A])
        else $error("Spare flag not set");

    AST_SPARE_B_SET: assert property ( // RULE2
        @(posedge mclk) disable iff (!reset_n)
        flagWr && sfrReq.wrData[FLAG_SPARE_B] |=> flags_ff[FLAG_SPARE_B])
        else $error("Second spare flag not set");

    AST_SPARE_HOLD: assert property ( // RULE2
        @(posedge mclk) disable iff (!reset_n)
        !flagWr && !flags_ff[FLAG_SPARE_B] |=> !flags_ff[FLAG_SPARE_B])
        else $error("Spare set by hardware");

    AST_SPARE_A_HOLD: assert property ( // RULE2
        @(posedge mclk) disable iff (!reset_n)
        !flagWr && !flags_ff[FLAG_SPARE_A] |=> !flags_ff[FLAG_SPARE_A])
        else $error("First spare set by hardware");

    AST_SER_SET: assert property ( // RULE3
        @(posedge mclk) disable iff (!reset_n)
        txHoldEmpty && !txEmpty_ff |=> flags_ff[FLAG_SERIALIZER])
        else $error("Serializer flag missed");

    AST_SER_HOLD: assert property ( // RULE3
        @(posedge mclk) disable iff (!reset_n)
        !flagWr && flags_ff[FLAG_SERIALIZER] |=> flags_ff[FLAG_SERIALIZER])
        else $error("Serializer flag cleared by hardware");

    AST_EDGE_SET: assert property ( // RULE5
        @(posedge mclk) disable iff (!reset_n)
        edgeHit[0] |=> flags_ff[FLAG_EXT_A])
        else $error("Edge flag missed");

    AST_EDGE_B_SET: assert property ( // RULE5
        @(posedge mclk) disable iff (!reset_n)
        edgeHit[1] |=> flags_ff[FLAG_EXT_B])
        else $error("Second edge flag missed");

    AST_NO_HW_CLEAR: assert property ( // RULE5
        @(posedge mclk) disable iff (!reset_n)
        !flagWr && flags_ff[FLAG_EXT_B] |=> flags_ff[FLAG_EXT_B])
        else $error("Flag cleared by hardware");

    AST_NO_HW_CLEAR_A: assert property ( // RULE5
        @(posedge mclk) disable iff (!reset_n)
        !flagWr && flags_ff[FLAG_EXT_A] |=> flags_ff[FLAG_EXT_A])
        else $error("First flag cleared by hardware");

    AST_REQ_EDGE_B: assert property ( // RULE15
        @(posedge mclk) disable iff (!reset_n)
        flags_ff[FLAG_EXT_B] && irqCtrl.enable[FLAG_EXT_B]
        |-> irqReq[FLAG_EXT_B])
        else $error("Enabled edge request missing");

    AST_SW_CLEAR: assert property ( // RULE14
        @(posedge mclk) disable iff (!reset_n)
        flagWr && !sfrReq.wrData[FLAG_SPARE_B] |=> !flags_ff[FLAG_SPARE_B])
        else $error("Software clear ignored");

    AST_REQ_RAISED: assert property ( // RULE14
        @(posedge mclk) disable iff (!reset_n)
        flags_ff[FLAG_SPARE_B] && irqCtrl.enable[FLAG_SPARE_B]
        |-> irqReq[FLAG_SPARE_B])
        else $error("Enabled spare request missing");

    AST_IRQ_MASK: assert property ( // RULE15
        @(posedge mclk) disable iff (!reset_n)
        !irqCtrl.enable[FLAG_EXT_A] |-> !irqReq[FLAG_EXT_A])
        else $error("Masked request asserted");

    AST_IRQ_MASK_B: assert property ( // RULE15
        @(posedge mclk) disable iff (!reset_n)
        !irqCtrl.enable[FLAG_EXT_B] |-> !irqReq[FLAG_EXT_B])
        else $error("Second masked request asserted");

    AST_NO_LEVEL: assert property ( // RULE6
        @(posedge mclk) disable iff (!reset_n)
        (settle_ff != 2'h0) && $stable(srcLevel) &&
        $stable(irqCtrl.doubleEdge) |-> edgeHit == 2'h0)
        else $error("Edge on steady level");

    AST_RISE_ONLY: assert property ( // RULE7
        @(posedge mclk) disable iff (!reset_n)
        (settle_ff != 2'h0) && !irqCtrl.doubleEdge[0] &&
        $fell(srcLevel[0]) |-> !edgeHit[0])
        else $error("Falling edge seen in single edge mode");

    AST_BOTH_EDGES: assert property ( // RULE7
        @(posedge mclk) disable iff (!reset_n)
        (settle_ff != 2'h0) && irqCtrl.doubleEdge[1] &&
        $changed(srcLevel[1]) |-> edgeHit[1])
        else $error("Edge missed in double edge mode");

    AST_SEL_A_ALT: assert property ( // RULE10
        @(posedge mclk) disable iff (!reset_n)
        (pinCfg_ff[EXT_A_SEL_LSB +: 3] == 3'h5) && !pinCfg_ff[EXT_A_INVERT]
        |-> srcLevel[0] == pinSync_ff[EXT_A_ALT_PIN])
        else $error("First source alternate pin wrong");

    AST_SEL_B_ALT: assert property ( // RULE9
        @(posedge mclk) disable iff (!reset_n)
        (pinCfg_ff[EXT_B_SEL_LSB +: 3] == 3'h5) && !pinCfg_ff[EXT_B_INVERT]
        |-> srcLevel[1] == pinSync_ff[EXT_B_ALT_PIN])
        else $error("Second source alternate pin wrong");

    AST_SEL_LOW: assert property ( // RULE9
        @(posedge mclk) disable iff (!reset_n)
        (pinCfg_ff[EXT_B_SEL_LSB +: 3] == 3'h6) && !pinCfg_ff[EXT_B_INVERT]
        |-> srcLevel[1] == pinSync_ff[6])
        else $error("Second source pin six wrong");

    AST_INVERT: assert property ( // RULE8
        @(posedge mclk) disable iff (!reset_n)
        (pinCfg_ff[EXT_A_SEL_LSB +: 3] == 3'h0) && pinCfg_ff[EXT_A_INVERT]
        |-> srcLevel[0] != pinSync_ff[0])
        else $error("Polarity bit did not invert");

    AST_SYNC_TWO: assert property ( // RULE11
        @(posedge mclk) disable iff (!reset_n)
        (settle_ff == 2'h3) |-> pinSync_ff == $past(gpioPin, 2))
        else $error("Pin sampler depth wrong");

    AST_CAPTURE: assert property ( // RULE13
        @(posedge mclk) disable iff (!reset_n)
        timer3Capture |=> flags_ff[FLAG_EXT_B])
        else $error("Capture without flag");

    AST_CAPTURE_A: assert property ( // RULE13
        @(posedge mclk) disable iff (!reset_n)
        timer2Capture |=> flags_ff[FLAG_EXT_A])
        else $error("First capture without flag");

endmodule

/* File: verification/cpu_sfr_model.sv */
// Purpose: CPU core model that owns the register bus
// Assumes: One access at a time, strobes one cycle wide
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/100ps
module cpu_sfr_model (
    input  wire logic                 mclk,
    output edge_irq_pkg::sfr_req_type req,
    input  wire logic [7:0]           rdData
);
    import edge_irq_pkg::*;
    initial req = '0;
    // Launch after an edge, release after the sampling edge
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        req <= '{w, !w, a, d};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, ~d};
        #1 q = rdData;
    endtask
endmodule

/* File: verification/edge_irq_pin_flags_tb.sv */
// Purpose: Self-checking bench for the edge interrupt flag unit
// Assumes: Pins change only at clock edges, held four cycles
// Notes:   Flag waits follow the fixed two-stage sampler latency
`timescale 1ns/100ps
module edge_irq_pin_flags_tb;
    import edge_irq_pkg::*;
    logic         mclk = 0, reset_n = 0, txHoldEmpty = 0;
    logic [9:0]   gpioPin = '0;
    irq_ctrl_type irqCtrl = '0;
    sfr_req_type  sfrReq;
    logic [7:0]   sfrRdData, q;
    logic [4:0]   irqReq;
    logic         timer2Capture, timer3Capture;
    int           failures = 0, n_checks = 0, capA = 0, capB = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        capA <= capA + int'(timer2Capture === 1'b1);
        capB <= capB + int'(timer3Capture === 1'b1);
    end
    cpu_sfr_model cpu (.mclk(mclk), .req(sfrReq), .rdData(sfrRdData));
    edge_irq_pin_flags uut (.mclk(mclk), .reset_n(reset_n),
        .sfrReq(sfrReq), .sfrRdData(sfrRdData), .irqCtrl(irqCtrl),
        .gpioPin(gpioPin), .txHoldEmpty(txHoldEmpty), .irqReq(irqReq),
        .timer2Capture(timer2Capture), .timer3Capture(timer3Capture));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cpu.access(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask
    // Longer than two sampling periods, so the sampler cannot miss it
    task automatic toggle(input logic [3:0] pin, input logic lvl);
        @(posedge mclk) gpioPin[pin] <= lvl;
        repeat (4) @(posedge mclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        rd(8'hBF, 8'h00);
        wr(8'hB7, 8'hA5);
        rd(8'hB7, 8'hA5);
        rd(8'h3C, 8'h00);
        wr(8'hBF, 8'hF8);
        rd(8'hBF, 8'h18);
        @(posedge mclk) irqCtrl <= '{5'h10, 2'b00};
        @(posedge mclk) #1 check({3'h0, irqReq}, 8'h10);
        wr(8'hBF, 8'h00);
        rd(8'hBF, 8'h00);
        check({3'h0, irqReq}, 8'h00);
        @(posedge mclk) txHoldEmpty <= 1'b1;
        repeat (3) @(posedge mclk);
        txHoldEmpty <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(8'hBF, 8'h04);
        wr(8'hBF, 8'h00);
        rd(8'hBF, 8'h00);
        $display("test_regs done");
    endtask
    // Masked sources: flags still set, requests stay low
    task automatic test_pins;
        logic [3:0] pa, pb;
        int ca;
        int cb;
        @(posedge mclk) irqCtrl <= '0;
        for (int k = 0; k < 8; k++) begin
            pa = (k == 5) ? 4'h8 : 4'(k);
            pb = (k == 5) ? 4'h9 : 4'(k);
            wr(8'hB7, {1'b0, 3'(k), 1'b0, 3'(k)});
            ca = capA;
            cb = capB;
            toggle(pa, 1'b1);
            toggle(pa, 1'b0);
            rd(8'hBF, (pa == pb) ? 8'h03 : 8'h01);
            check({3'h0, irqReq}, 8'h00);
            check(8'(capA - ca), 8'h01);
            toggle(pb, 1'b1);
            check(8'(capB - cb), (pa == pb) ? 8'h02 : 8'h01);
            toggle(pb, 1'b0);
            wr(8'hBF, 8'h00);
        end
        $display("test_pins done");
    endtask
    task automatic test_modes;
        wr(8'hB7, 8'h08);
        repeat (4) @(posedge mclk);
        wr(8'hBF, 8'h00);
        toggle(4'h0, 1'b1);
        rd(8'hBF, 8'h02);
        wr(8'hBF, 8'h00);
        repeat (6) @(posedge mclk);
        rd(8'hBF, 8'h00);
        toggle(4'h0, 1'b0);
        rd(8'hBF, 8'h01);
        @(posedge mclk) irqCtrl <= '{5'h03, 2'b11};
        wr(8'hBF, 8'h00);
        toggle(4'h0, 1'b1);
        rd(8'hBF, 8'h03);
        check({3'h0, irqReq}, 8'h03);
        $display("test_modes done");
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        test_regs();
        test_pins();
        test_modes();
        give_verdict();
    end
endmodule
